// *** rtl/ies_pkg.sv ***
// Package of constants and types for the instruction exception sequencer
package ies_pkg;
  // ----------------------------------------------------------------
  // Widths and vector numbers
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned VEC_W = 8;
  localparam logic [7:0] VEC_ILLEGAL_GENERAL = 8'h04;
  localparam logic [7:0] VEC_ILLEGAL_SLOT = 8'h06;
  localparam logic [7:0] VEC_ADDR_ERROR = 8'h09;
  // Stack step per pushed longword, vector entry scale
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;
  localparam int unsigned VEC_SHIFT = 2;
  // Reset values
  localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
  localparam logic [7:0] RESET_VEC = 8'h00;

  // ----------------------------------------------------------------
  // Exception kinds and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IES_KIND_NONE = 3'b000,
    IES_KIND_TRAP = 3'b001,
    IES_KIND_SLOT = 3'b010,
    IES_KIND_GENERAL = 3'b011,
    IES_KIND_ADDR = 3'b100,
    IES_KIND_INTR = 3'b101
  } ies_kind_t;

  typedef enum logic [2:0] {
    IES_IDLE = 3'b000,
    IES_PUSH_SR = 3'b001,
    IES_PUSH_PC = 3'b010,
    IES_VEC_RD = 3'b011,
    IES_JUMP = 3'b100
  } ies_state_t;
endpackage : ies_pkg

// *** rtl/ies_sequencer.sv ***
// Exception sequencer: detection, deferral, stacking and vectoring
`timescale 1ns/10ps
// Summary of operation
// - Trap pushes status then next-instruction address
// - Trap vectors by its own number, no slot
// - Instruction after a delayed branch not itself in a slot is slot
// - Undefined code in slot raises illegal slot
// - PC-altering instruction in slot raises illegal slot
// - Illegal slot stacks the branch target address
// - Illegal slot vectors to its handler, non-delayed
// - General illegal stacks the undefined code address
// - Deferred address error or interrupt taken later
// - Slot decode accepts no address error, interrupt
// - After control transfer, block interrupts only
// - Frame: return address at SP, status above
// - Stacking misalignment: finish, then address error
// - Address error stacking ignores further address errors
// - Misaligned pushes still run, SP minus four
// - Flag misaligned word and longword accesses
// - Address error waits for cycle and instruction
module ies_sequencer (
  input wire logic sys_clk,
  input wire logic reset,
  // Decode stage
  input wire logic dec_valid,
  input wire logic dec_undefined,
  input wire logic dec_trap_instruction,
  input wire logic [7:0] dec_trap_vector,
  input wire logic dec_delayed_branch,
  input wire logic dec_pc_write,
  input wire logic dec_ctrl_transfer,
  input wire logic [31:0] dec_program_counter,
  input wire logic [31:0] dec_next_pc,
  input wire logic [31:0] dec_branch_target,
  input wire logic [31:0] status_word,
  input wire logic [31:0] stack_pointer,
  input wire logic [31:0] vector_base,
  // Interrupt request from the arbiter
  input wire logic int_req,
  input wire logic [7:0] int_vector,
  // Bus access monitor for misalignment
  input wire logic mon_valid,
  input wire logic mon_word,
  input wire logic mon_long,
  input wire logic [31:0] mon_addr,
  // Exception bus master
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  output logic bus_req,
  output logic bus_write,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata,
  // Core control
  output logic fetch_hold,
  output logic pc_load,
  output logic [31:0] pc_load_value,
  output logic sp_load,
  output logic [31:0] sp_load_value,
  output logic int_ack,
  output logic in_slot,
  output logic [2:0] exc_kind
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ies_pkg::ies_state_t state, next_state;
  ies_pkg::ies_kind_t kind, next_kind;
  logic slot, next_slot;
  logic int_block, next_int_block;
  logic ae_pend, next_ae_pend;
  logic int_pend, next_int_pend;
  logic [31:0] ret_addr, next_ret_addr;
  logic [31:0] saved_sr, next_saved_sr;
  logic [31:0] sp_work, next_sp_work;
  logic [7:0] vec, next_vec;
  logic next_bus_req, next_bus_write, next_fetch_hold;
  logic [31:0] next_bus_addr, next_bus_wdata;
  logic next_pc_load, next_sp_load, next_int_ack;
  logic [31:0] next_pc_load_value, next_sp_load_value;
  logic mis, slot_illegal;

  // Misaligned word or longword access
  function automatic logic misaligned(input logic w, input logic l, input logic [31:0] a);
    misaligned = (w && a[0]) || (l && (a[1:0] != 2'b00));
  endfunction : misaligned

  // Vector entry address
  function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] v);
    vec_addr = base + ({24'h0000_00, v} << ies_pkg::VEC_SHIFT);
  endfunction : vec_addr

  assign mis = mon_valid && misaligned(mon_word, mon_long, mon_addr);
  assign slot_illegal = slot && (dec_undefined || dec_pc_write || dec_trap_instruction);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_slot = slot;
    next_int_block = int_block;
    next_ae_pend = ae_pend;
    next_int_pend = int_pend;
    next_ret_addr = ret_addr;
    next_saved_sr = saved_sr;
    next_sp_work = sp_work;
    next_vec = vec;
    next_bus_req = 1'b0;
    next_bus_write = 1'b0;
    next_bus_addr = bus_addr;
    next_bus_wdata = bus_wdata;
    next_fetch_hold = fetch_hold;
    next_pc_load = 1'b0;
    next_pc_load_value = pc_load_value;
    next_sp_load = 1'b0;
    next_sp_load_value = sp_load_value;
    next_int_ack = 1'b0;
    // Collect address errors; ignored while stacking for an address error
    if (mis && !(state != ies_pkg::IES_IDLE && kind == ies_pkg::IES_KIND_ADDR)) begin
      next_ae_pend = 1'b1;
    end
    // Latch a level request only while idle, so a request being serviced is not re-armed
    if (int_req && state == ies_pkg::IES_IDLE) begin
      next_int_pend = 1'b1;
    end
    case (state)
      ies_pkg::IES_IDLE: begin
        if (dec_valid) begin
          next_slot = dec_delayed_branch && !slot;
          next_int_block = dec_ctrl_transfer;
          next_saved_sr = status_word;
          next_sp_work = stack_pointer;
          next_kind = ies_pkg::IES_KIND_NONE;
          if (slot_illegal) begin
            next_kind = ies_pkg::IES_KIND_SLOT;
            next_ret_addr = dec_branch_target;
            next_vec = ies_pkg::VEC_ILLEGAL_SLOT;
          end else if (slot) begin
            next_kind = ies_pkg::IES_KIND_NONE;
          end else if (dec_undefined) begin
            next_kind = ies_pkg::IES_KIND_GENERAL;
            next_ret_addr = dec_program_counter;
            next_vec = ies_pkg::VEC_ILLEGAL_GENERAL;
          end else if (ae_pend || mis) begin
            next_kind = ies_pkg::IES_KIND_ADDR;
            next_ae_pend = 1'b0;
            next_ret_addr = dec_program_counter;
            next_vec = ies_pkg::VEC_ADDR_ERROR;
          end else if ((int_pend || int_req) && !int_block) begin
            next_kind = ies_pkg::IES_KIND_INTR;
            next_int_pend = 1'b0;
            next_int_ack = 1'b1;
            next_ret_addr = dec_program_counter;
            next_vec = int_vector;
          end else if (dec_trap_instruction) begin
            next_kind = ies_pkg::IES_KIND_TRAP;
            next_ret_addr = dec_next_pc;
            next_vec = dec_trap_vector;
          end
          if (next_kind != ies_pkg::IES_KIND_NONE) begin
            next_slot = 1'b0;
            next_state = ies_pkg::IES_PUSH_SR;
            next_fetch_hold = 1'b1;
            next_sp_work = stack_pointer - ies_pkg::STACK_STEP;
            next_bus_req = 1'b1;
            next_bus_write = 1'b1;
            next_bus_addr = stack_pointer - ies_pkg::STACK_STEP;
            next_bus_wdata = status_word;
          end
        end
      end
      ies_pkg::IES_PUSH_SR: begin
        next_bus_req = 1'b1;
        next_bus_write = 1'b1;
        if (bus_ack) begin
          next_state = ies_pkg::IES_PUSH_PC;
          next_sp_work = sp_work - ies_pkg::STACK_STEP;
          next_bus_addr = sp_work - ies_pkg::STACK_STEP;
          next_bus_wdata = ret_addr;
        end
      end
      ies_pkg::IES_PUSH_PC: begin
        next_bus_req = 1'b1;
        next_bus_write = 1'b1;
        if (bus_ack) begin
          next_state = ies_pkg::IES_VEC_RD;
          next_bus_write = 1'b0;
          next_bus_addr = vec_addr(vector_base, vec);
          next_sp_load = 1'b1;
          next_sp_load_value = sp_work;
        end
      end
      ies_pkg::IES_VEC_RD: begin
        next_bus_req = 1'b1;
        if (bus_ack) begin
          next_bus_req = 1'b0;
          next_state = ies_pkg::IES_JUMP;
          next_pc_load = 1'b1;
          next_pc_load_value = bus_rdata;
        end
      end
      ies_pkg::IES_JUMP: begin
        // Pending stacking error waits in IDLE and starts its own sequence at the next decoded instruction
        next_fetch_hold = 1'b0;
        next_state = ies_pkg::IES_IDLE;
        next_kind = ies_pkg::IES_KIND_NONE;
      end
      default: begin
        next_state = ies_pkg::IES_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= ies_pkg::IES_IDLE;
      kind <= ies_pkg::IES_KIND_NONE;
      slot <= 1'b0;
      int_block <= 1'b0;
      ae_pend <= 1'b0;
      int_pend <= 1'b0;
      ret_addr <= ies_pkg::RESET_ADDR;
      saved_sr <= ies_pkg::RESET_ADDR;
      sp_work <= ies_pkg::RESET_ADDR;
      vec <= ies_pkg::RESET_VEC;
      bus_req <= 1'b0;
      bus_write <= 1'b0;
      bus_addr <= ies_pkg::RESET_ADDR;
      bus_wdata <= ies_pkg::RESET_ADDR;
      fetch_hold <= 1'b0;
      pc_load <= 1'b0;
      pc_load_value <= ies_pkg::RESET_ADDR;
      sp_load <= 1'b0;
      sp_load_value <= ies_pkg::RESET_ADDR;
      int_ack <= 1'b0;
      in_slot <= 1'b0;
      exc_kind <= 3'b000;
    end else begin
      state <= next_state;
      kind <= next_kind;
      slot <= next_slot;
      int_block <= next_int_block;
      ae_pend <= next_ae_pend;
      int_pend <= next_int_pend;
      ret_addr <= next_ret_addr;
      saved_sr <= next_saved_sr;
      sp_work <= next_sp_work;
      vec <= next_vec;
      bus_req <= next_bus_req;
      bus_write <= next_bus_write;
      bus_addr <= next_bus_addr;
      bus_wdata <= next_bus_wdata;
      fetch_hold <= next_fetch_hold;
      pc_load <= next_pc_load;
      pc_load_value <= next_pc_load_value;
      sp_load <= next_sp_load;
      sp_load_value <= next_sp_load_value;
      int_ack <= next_int_ack;
      in_slot <= next_slot;
      exc_kind <= next_kind;
    end
  end
endmodule : ies_sequencer

// *** bench/ies_bus_model.sv ***
// Memory bus responder model for the sequencer's stacking and vector cycles
`timescale 1ns/10ps
module ies_bus_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  output logic mon_valid,
  output logic mon_word,
  output logic mon_long,
  output logic [31:0] mon_addr
);
  logic [1:0] wait_cnt;
  logic slow;
  // Ack after zero or two cycles in turn; read data only valid with ack
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_ack <= 1'b0;
      wait_cnt <= 2'h0;
      slow <= 1'b0;
      bus_rdata <= 32'h0000_0000;
    end else if (!bus_ack && bus_req && wait_cnt == {slow, 1'b0}) begin
      bus_ack <= 1'b1;
      wait_cnt <= 2'h0;
      slow <= ~slow;
      bus_rdata <= bus_write ? ~bus_rdata : bus_addr + 32'h1000_0000;
    end else begin
      bus_ack <= 1'b0;
      wait_cnt <= (bus_req && !bus_ack) ? wait_cnt + 2'h1 : 2'h0;
      bus_rdata <= ~bus_rdata;
    end
  end
  // Every completed cycle is reported as a longword access
  assign mon_valid = bus_req & bus_ack;
  assign mon_word = 1'b0;
  assign mon_long = 1'b1;
  assign mon_addr = bus_addr;
endmodule : ies_bus_model

// *** bench/ies_sequencer_asserts.sv ***
// Port checker for the exception sequencer
`timescale 1ns/10ps
module ies_sequencer_asserts (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic dec_valid,
  input wire logic [31:0] status_word,
  input wire logic [31:0] stack_pointer,
  input wire logic [31:0] vector_base,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic fetch_hold,
  input wire logic pc_load,
  input wire logic [31:0] pc_load_value,
  input wire logic int_ack,
  input wire logic in_slot,
  input wire logic [2:0] exc_kind
);
  localparam logic [31:0] S4 = ies_pkg::STACK_STEP;
  logic [1:0] wr_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Count writes completed in the current sequence
  always_ff @(posedge sys_clk) begin
    if (reset || !bus_req) wr_n <= 2'h0;
    else if (bus_ack && bus_write) wr_n <= wr_n + 2'h1;
  end
  a_status_first: assert property ($rose(bus_req) |-> bus_write &&
    bus_addr == $past(stack_pointer) - S4 && bus_wdata == $past(status_word))
    else $error("first push wrong");
  a_return_below: assert property (bus_req && bus_ack && bus_write && wr_n == 2'h0
    |=> bus_write && bus_addr == $past(bus_addr) - S4) else $error("second push wrong");
  a_vector_read: assert property (bus_req && wr_n == 2'h2 |-> !bus_write)
    else $error("third cycle not a read");
  a_slot_vector: assert property (bus_req && wr_n == 2'h2 && exc_kind == 3'h2
    |-> bus_addr == vector_base + {22'h0, ies_pkg::VEC_ILLEGAL_SLOT, 2'h0})
    else $error("slot vector address wrong");
  a_jump_value: assert property (bus_req && !bus_write && bus_ack |=> pc_load &&
    !bus_req && pc_load_value == $past(bus_rdata)) else $error("handler load wrong");
  a_fetch_held: assert property (bus_req |-> fetch_hold)
    else $error("fetch not held");
  a_req_stands: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr))
    else $error("request dropped early");
  a_slot_no_intr: assert property (in_slot && dec_valid && !fetch_hold |=> !int_ack)
    else $error("interrupt in slot");
endmodule : ies_sequencer_asserts
bind ies_sequencer ies_sequencer_asserts u_chk (.sys_clk, .reset, .dec_valid, .status_word,
  .stack_pointer, .vector_base, .bus_ack, .bus_rdata, .bus_req, .bus_write, .bus_addr,
  .bus_wdata, .fetch_hold, .pc_load, .pc_load_value, .int_ack, .in_slot, .exc_kind);

// *** bench/test_ies_sequencer.sv ***
// Self-checking bench for the exception sequencer
`timescale 1ns/10ps
module test_ies_sequencer;
  logic sys_clk, reset, dec_valid, dec_undefined, dec_trap_instruction, in_slot;
  logic dec_delayed_branch, dec_pc_write, dec_ctrl_transfer, int_req, bus_ack;
  logic mon_valid, mon_word, mon_long, bus_req, bus_write, fetch_hold, pc_load;
  logic [31:0] dec_program_counter, dec_next_pc, stack_pointer, mon_addr, bus_rdata;
  logic [31:0] bus_addr, bus_wdata, pc_load_value, sp_load_value;
  logic sp_load, int_ack;
  logic [2:0] exc_kind;
  int err_total = 0;
  int check_count = 0;
  localparam logic [31:0] TGT = 32'h0000_4000;
  localparam logic [31:0] SR = 32'h0000_00F0;
  localparam logic [31:0] VB = 32'h0000_0800;
  ies_sequencer dut (.sys_clk, .reset, .dec_valid, .dec_undefined, .dec_trap_instruction,
    .dec_trap_vector(8'h21), .dec_delayed_branch, .dec_pc_write, .dec_ctrl_transfer,
    .dec_program_counter, .dec_next_pc, .dec_branch_target(TGT), .status_word(SR),
    .stack_pointer, .vector_base(VB), .int_req, .int_vector(8'h40), .mon_valid, .mon_word,
    .mon_long, .mon_addr, .bus_ack, .bus_rdata, .bus_req, .bus_write, .bus_addr, .bus_wdata,
    .fetch_hold, .pc_load, .pc_load_value, .sp_load, .sp_load_value, .int_ack,
    .in_slot, .exc_kind);
  ies_bus_model far_end (.sys_clk, .reset, .bus_req, .bus_write, .bus_addr, .bus_ack,
    .bus_rdata, .mon_valid, .mon_word, .mon_long, .mon_addr);
  // Clock at 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One decoded instruction, flags {undef, trap, dbranch, pc_write, ctrl}
  task automatic dec(input logic [4:0] f, input logic [31:0] pc);
    @(posedge sys_clk);
    dec_valid <= 1'b1;
    {dec_undefined, dec_trap_instruction, dec_delayed_branch, dec_pc_write,
      dec_ctrl_transfer} <= f;
    dec_program_counter <= pc;
    dec_next_pc <= pc + 32'h0000_0002;
    @(posedge sys_clk);
    dec_valid <= 1'b0;
  endtask : dec
  // Follow one whole exception entry on the bus
  task automatic frame(input logic [2:0] k, input logic [31:0] ret, input logic [7:0] v,
      input bit ck);
    int n;
    n = 0;
    for (int i = 0; i < 60 && n < 3; i++) begin
      @(negedge sys_clk);
      if (sp_load === 1'b1) chk(sp_load_value, stack_pointer - 32'h0000_0008);
      if (bus_req === 1'b1 && bus_ack === 1'b1) begin
        if (n == 0) begin
          chk(bus_addr, stack_pointer - 32'h0000_0004);
          chk(bus_wdata, SR);
          chk({29'h0, exc_kind}, {29'h0, k});
        end else if (n == 1) begin
          chk(bus_addr, stack_pointer - 32'h0000_0008);
          if (ck) chk(bus_wdata, ret);
        end else begin
          chk({31'h0, bus_write}, 32'h0000_0000);
          chk(bus_addr, VB + {22'h0, v, 2'h0});
        end
        n++;
      end
    end
    chk(32'(n), 32'h0000_0003);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (pc_load !== 1'b1 && n < 10);
    chk(pc_load_value, VB + {22'h0, v, 2'h0} + 32'h1000_0000);
    @(negedge sys_clk);
    chk({31'h0, fetch_hold}, 32'h0000_0000);
  endtask : frame
  task automatic quiet;
    repeat (8) begin
      @(negedge sys_clk);
      chk({31'h0, bus_req}, 32'h0000_0000);
      chk({31'h0, int_ack}, 32'h0000_0000);
    end
  endtask : quiet
  task automatic t_trap;
    dec(5'b01000, 32'h0000_0100);
    frame(ies_pkg::IES_KIND_TRAP, 32'h0000_0102, 8'h21, 1'b1);
  endtask : t_trap
  task automatic t_slot;
    logic [4:0] kinds [3] = '{5'b10000, 5'b01000, 5'b00110};
    foreach (kinds[j]) begin
      dec(5'b00110, 32'h0000_0200);
      dec(kinds[j], 32'h0000_0202);
      frame(ies_pkg::IES_KIND_SLOT, TGT, ies_pkg::VEC_ILLEGAL_SLOT, 1'b1);
    end
  endtask : t_slot
  task automatic t_general;
    dec(5'b10000, 32'h0000_0300);
    frame(ies_pkg::IES_KIND_GENERAL, 32'h0000_0300, ies_pkg::VEC_ILLEGAL_GENERAL, 1'b1);
  endtask : t_general
  // Interrupt raised right after a delayed branch, then after a control transfer
  task automatic t_defer;
    logic [4:0] opener [2] = '{5'b00110, 5'b00001};
    foreach (opener[j]) begin
      dec(opener[j], 32'h0000_0400);
      int_req <= 1'b1;
      dec(5'b00000, 32'h0000_0402);
      quiet();
      dec(5'b00000, 32'h0000_0404);
      @(negedge sys_clk);
      chk({31'h0, int_ack}, 32'h0000_0001);
      @(posedge sys_clk);
      int_req <= 1'b0;
      frame(ies_pkg::IES_KIND_INTR, 32'h0000_0404, 8'h40, 1'b1);
    end
  endtask : t_defer
  // Stack pointer deliberately off a longword boundary
  task automatic t_misalign;
    @(posedge sys_clk);
    stack_pointer <= 32'h0000_2002;
    dec(5'b01000, 32'h0000_0600);
    frame(ies_pkg::IES_KIND_TRAP, 32'h0000_0000, 8'h21, 1'b0);
    dec(5'b00000, 32'h0000_0602);
    frame(ies_pkg::IES_KIND_ADDR, 32'h0000_0000, ies_pkg::VEC_ADDR_ERROR, 1'b0);
    dec(5'b00000, 32'h0000_0604);
    quiet();
    stack_pointer <= 32'h0000_3000;
  endtask : t_misalign
  task automatic final_report;
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // Watchdog against a hung sequence
  initial begin
    #200us;
    err_total++;
    final_report();
  end
  initial begin
    {dec_valid, dec_undefined, dec_trap_instruction, dec_delayed_branch} = 4'h0;
    {dec_pc_write, dec_ctrl_transfer, int_req} = 3'h0;
    dec_program_counter = 32'h0000_0000;
    dec_next_pc = 32'h0000_0000;
    stack_pointer = 32'h0000_3000;
    reset = 1'b1;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_trap();
    t_slot();
    t_general();
    t_defer();
    t_misalign();
    final_report();
  end
endmodule : test_ies_sequencer
